/* rtl/hall_wake_pkg.sv */
package hall_wake_pkg;

  // register addresses on the plain register port
  localparam logic [7:0] irq_mask_addr = 8'h04;
  localparam logic [7:0] irq_flag_addr = 8'h05;
  localparam logic [7:0] reset_status_addr = 8'h06;
  localparam logic [7:0] hall_wake_status_control_addr = 8'h07;

  // field positions in hall_wake_status_control
  localparam int ctl_mode_select_bit = 0;
  localparam int ctl_pullup_disable_bit = 1;
  localparam int ctl_port_enable_bit = 2;
  localparam int ctl_hall_flag_bit = 3;
  localparam int ctl_overcurrent_bit = 4;
  localparam int ctl_wake_flag_bit = 5;

  // field positions in mask, flag and reset status registers
  localparam int irq_hall_bit = 0;
  localparam int irq_wake_bit = 1;
  localparam int rst_wake_source_bit = 0;

  // values after reset
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [1:0] startup_cycles = 2'h3;

  // hall sensor settling time before software may sample
  localparam int clk_period_ns = 25;
  localparam int hall_settle_time_us = 40;
  localparam int hall_settle_cycles = (hall_settle_time_us * 1000 + clk_period_ns - 1)
                                      / clk_period_ns;

  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_stop = 2'b01,
    mode_sleep = 2'b10
  } power_mode_type;

  typedef struct packed {
    logic mode_select;
    logic pullup_disable;
    logic port_enable;
  } hall_ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_type;

  // sticky flag update: a set in the clearing cycle wins
  function automatic logic sticky_flag(input logic flag, input logic set, input logic clr);
    sticky_flag = set | (flag & ~clr);
  endfunction

endpackage

/* rtl/input_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter logic reset_level = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // the first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= reset_level;
      sync_reg <= reset_level;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* rtl/wake_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_latch (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire hall_wake_pkg::power_mode_type power_mode,
  input wire logic wake_level,
  output logic wake_request,
  output logic wake_event
);
  import hall_wake_pkg::*;

  logic low_power_reg;
  logic low_power_next;
  logic latched_reg;
  logic latched_next;
  logic request_reg;
  logic request_next;
  logic in_low_power;

  // stop and sleep both arm the wake comparison
  always_comb begin
    case (power_mode)
      mode_run: in_low_power = 1'b0;
      mode_stop: in_low_power = 1'b1;
      mode_sleep: in_low_power = 1'b1;
      default: in_low_power = 1'b0;
    endcase
  end

  always_comb begin
    low_power_next = in_low_power;
    latched_next = latched_reg;
    request_next = request_reg;
    if (in_low_power && !low_power_reg) begin
      latched_next = wake_level;
    end
    if (!in_low_power) begin
      request_next = 1'b0;
    end else if (low_power_reg && (wake_level != latched_reg)) begin
      request_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_power_reg <= 1'b0;
      latched_reg <= 1'b0;
      request_reg <= 1'b0;
    end else begin
      low_power_reg <= low_power_next;
      latched_reg <= latched_next;
      request_reg <= request_next;
    end
  end

  assign wake_request = request_reg;
  assign wake_event = request_next & ~request_reg;

  property p_wake_start;
    @(posedge clk_sys) disable iff (!reset_n)
    (low_power_reg && in_low_power && (wake_level != latched_reg)) |=> wake_request;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wake change did not wake");
endmodule
`default_nettype wire

/* rtl/hall_wake_input_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module hall_wake_input_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire hall_wake_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire hall_wake_pkg::power_mode_type power_mode,
  input wire logic hall_input_pin,
  input wire logic hall_current_below,
  input wire logic hall_overcurrent_det,
  input wire logic wake_input_pin,
  output logic hall_supply_drive,
  output logic hall_sense_enable,
  output logic hall_current_limit,
  output logic hall_pullup_enable,
  output logic hall_irq,
  output logic wake_irq,
  output logic wake_request
);
  import hall_wake_pkg::*;

  logic hall_pin_s;
  logic hall_cur_s;
  logic hall_oc_s;
  logic wake_pin_s;
  logic wake_event;

  hall_ctrl_type ctrl_reg;
  hall_ctrl_type ctrl_next;
  logic overcurrent_reg;
  logic overcurrent_next;
  logic limit_reg;
  logic limit_next;
  logic hall_ie_reg;
  logic hall_ie_next;
  logic wake_ie_reg;
  logic wake_ie_next;
  logic hall_if_reg;
  logic hall_if_next;
  logic wake_if_reg;
  logic wake_if_next;
  logic wake_src_reg;
  logic wake_src_next;
  logic hall_prev_reg;
  logic hall_prev_next;
  logic wake_prev_reg;
  logic wake_prev_next;
  logic [1:0] startup_reg;
  logic [1:0] startup_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic hall_flag;
  logic oc_active;
  logic in_run;
  logic edges_armed;
  logic hall_change;
  logic wake_change;
  logic ctl_wr;
  logic mask_wr;
  logic flag_wr;
  logic rst_wr;
  logic [7:0] ctl_value;

  input_sync #(.reset_level(1'b1)) u_sync_hall_pin (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(hall_input_pin),
    .sync_out(hall_pin_s)
  );

  input_sync #(.reset_level(1'b1)) u_sync_hall_cur (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(hall_current_below),
    .sync_out(hall_cur_s)
  );

  input_sync #(.reset_level(1'b0)) u_sync_hall_oc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(hall_overcurrent_det),
    .sync_out(hall_oc_s)
  );

  input_sync #(.reset_level(1'b0)) u_sync_wake_pin (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(wake_input_pin),
    .sync_out(wake_pin_s)
  );

  // low power wake detection on the synchronised wake level
  wake_latch u_wake_latch (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .power_mode(power_mode),
    .wake_level(wake_pin_s),
    .wake_request(wake_request),
    .wake_event(wake_event)
  );

  always_comb begin
    if (!ctrl_reg.mode_select) begin
      hall_flag = hall_pin_s;
    end else if (ctrl_reg.port_enable) begin
      hall_flag = hall_cur_s;
    end else begin
      hall_flag = 1'b1; // port off draws no current
    end
  end

  // overcurrent only counts with the port on in hall mode
  assign oc_active = ctrl_reg.mode_select & ctrl_reg.port_enable & hall_oc_s;
  assign in_run = (power_mode == mode_run);
  // edges masked until the synchronisers hold real pin values
  assign edges_armed = (startup_reg == startup_cycles);
  assign hall_change = edges_armed & in_run & (hall_flag != hall_prev_reg);
  assign wake_change = edges_armed & in_run & (wake_pin_s != wake_prev_reg);

  assign ctl_wr = reg_req.write && (reg_req.addr == hall_wake_status_control_addr);
  assign mask_wr = reg_req.write && (reg_req.addr == irq_mask_addr);
  assign flag_wr = reg_req.write && (reg_req.addr == irq_flag_addr);
  assign rst_wr = reg_req.write && (reg_req.addr == reset_status_addr);

  // control register read image
  always_comb begin
    ctl_value = reg_reset_value;
    ctl_value[ctl_mode_select_bit] = ctrl_reg.mode_select;
    ctl_value[ctl_pullup_disable_bit] = ctrl_reg.pullup_disable;
    ctl_value[ctl_port_enable_bit] = ctrl_reg.port_enable;
    ctl_value[ctl_hall_flag_bit] = hall_flag;
    ctl_value[ctl_overcurrent_bit] = overcurrent_reg;
    ctl_value[ctl_wake_flag_bit] = wake_pin_s;
  end

  // next state of all software visible and edge state
  always_comb begin
    ctrl_next = ctrl_reg;
    hall_ie_next = hall_ie_reg;
    wake_ie_next = wake_ie_reg;
    hall_prev_next = hall_flag;
    wake_prev_next = wake_pin_s;
    startup_next = edges_armed ? startup_reg : startup_reg + 2'h1;
    limit_next = oc_active;
    if (ctl_wr) begin
      ctrl_next.mode_select = reg_req.wdata[ctl_mode_select_bit];
      ctrl_next.pullup_disable = reg_req.wdata[ctl_pullup_disable_bit];
      ctrl_next.port_enable = reg_req.wdata[ctl_port_enable_bit];
    end
    if (mask_wr) begin
      hall_ie_next = reg_req.wdata[irq_hall_bit];
      wake_ie_next = reg_req.wdata[irq_wake_bit];
    end
    overcurrent_next = sticky_flag(overcurrent_reg, oc_active,
                                   ctl_wr & reg_req.wdata[ctl_overcurrent_bit]);
    hall_if_next = sticky_flag(hall_if_reg, hall_change,
                               flag_wr & reg_req.wdata[irq_hall_bit]);
    wake_if_next = sticky_flag(wake_if_reg, wake_change,
                               flag_wr & reg_req.wdata[irq_wake_bit]);
    wake_src_next = sticky_flag(wake_src_reg, wake_event,
                                rst_wr & reg_req.wdata[rst_wake_source_bit]);
  end

  // read data stand only in the cycle after the strobe
  always_comb begin
    rdata_next = reg_reset_value;
    if (reg_req.read) begin
      case (reg_req.addr)
        hall_wake_status_control_addr: rdata_next = ctl_value;
        irq_mask_addr: begin
          rdata_next[irq_hall_bit] = hall_ie_reg;
          rdata_next[irq_wake_bit] = wake_ie_reg;
        end
        irq_flag_addr: begin
          rdata_next[irq_hall_bit] = hall_if_reg;
          rdata_next[irq_wake_bit] = wake_if_reg;
        end
        reset_status_addr: rdata_next[rst_wake_source_bit] = wake_src_reg;
        default: rdata_next = reg_reset_value;
      endcase
    end
  end

  // reset gives general input, sensing off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= '0;
      overcurrent_reg <= 1'b0;
      limit_reg <= 1'b0;
      hall_ie_reg <= 1'b0;
      wake_ie_reg <= 1'b0;
      hall_if_reg <= 1'b0;
      wake_if_reg <= 1'b0;
      wake_src_reg <= 1'b0;
      hall_prev_reg <= 1'b1;
      wake_prev_reg <= 1'b0;
      startup_reg <= 2'h0;
      rdata_reg <= reg_reset_value;
    end else begin
      ctrl_reg <= ctrl_next;
      overcurrent_reg <= overcurrent_next;
      limit_reg <= limit_next;
      hall_ie_reg <= hall_ie_next;
      wake_ie_reg <= wake_ie_next;
      hall_if_reg <= hall_if_next;
      wake_if_reg <= wake_if_next;
      wake_src_reg <= wake_src_next;
      hall_prev_reg <= hall_prev_next;
      wake_prev_reg <= wake_prev_next;
      startup_reg <= startup_next;
      rdata_reg <= rdata_next;
    end
  end

  // supply drive and sense only in hall mode
  assign hall_supply_drive = ctrl_reg.mode_select & ctrl_reg.port_enable;
  assign hall_sense_enable = ctrl_reg.mode_select & ctrl_reg.port_enable;
  assign hall_current_limit = limit_reg;
  assign hall_pullup_enable = ~ctrl_reg.mode_select & ~ctrl_reg.pullup_disable;
  assign hall_irq = hall_if_reg & hall_ie_reg;
  assign wake_irq = wake_if_reg & wake_ie_reg;
  assign reg_rdata = rdata_reg;

  property p_port_on;
    @(posedge clk_sys) disable iff (!reset_n)
    (ctl_wr && reg_req.wdata[ctl_mode_select_bit] && reg_req.wdata[ctl_port_enable_bit])
      |=> (hall_supply_drive && hall_sense_enable && !hall_pullup_enable);
  endproperty
  a_port_on: assert property (p_port_on) else $error("hall port not switched on");

  property p_pullup;
    @(posedge clk_sys) disable iff (!reset_n)
    (ctl_wr && !reg_req.wdata[ctl_mode_select_bit])
      |=> (hall_pullup_enable == !$past(reg_req.wdata[ctl_pullup_disable_bit]));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up state wrong");

  property p_oc_set;
    @(posedge clk_sys) disable iff (!reset_n)
    oc_active |=> (overcurrent_reg && hall_current_limit);
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("overcurrent not flagged");

  property p_oc_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (ctl_wr && reg_req.wdata[ctl_overcurrent_bit] && !oc_active) |=> !overcurrent_reg;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent flag not cleared");

  property p_hall_edge;
    @(posedge clk_sys) disable iff (!reset_n)
    hall_change |=> hall_if_reg;
  endproperty
  a_hall_edge: assert property (p_hall_edge) else $error("hall change missed");

  property p_no_edge_low_power;
    @(posedge clk_sys) disable iff (!reset_n)
    (!in_run && !hall_if_reg && !flag_wr) |=> !hall_if_reg;
  endproperty
  a_no_edge_low_power: assert property (p_no_edge_low_power)
    else $error("hall flag set outside run");

  property p_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
    (wake_if_reg && !(flag_wr && reg_req.wdata[irq_wake_bit])) |=> wake_if_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("wake flag dropped");

  property p_wake_edge;
    @(posedge clk_sys) disable iff (!reset_n)
    (wake_change && wake_ie_reg && !mask_wr) |=> wake_irq;
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("wake interrupt missing");

  property p_hall_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    !hall_ie_reg |-> !hall_irq;
  endproperty
  a_hall_mask: assert property (p_hall_mask) else $error("hall interrupt not masked");

  property p_hall_forward;
    @(posedge clk_sys) disable iff (!reset_n)
    (hall_change && hall_ie_reg && !mask_wr) |=> hall_irq;
  endproperty
  a_hall_forward: assert property (p_hall_forward) else $error("hall irq missing");

  property p_wake_src;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(wake_request) |-> wake_src_reg;
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake source flag missing");

  property p_read_slot;
    @(posedge clk_sys) disable iff (!reset_n)
    !$past(reg_req.read) |-> (reg_rdata == 8'h00);
  endproperty
  a_read_slot: assert property (p_read_slot) else $error("read data outside slot");
endmodule
`default_nettype wire

/* sim/hall_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// external switch or 2-pin hall sensor on the hall pin
module hall_sensor_model (
  input wire logic clk_sys,
  input wire logic hall_supply_drive,
  input wire logic hall_sense_enable,
  input wire logic hall_pullup_enable,
  input wire logic switch_closed,
  input wire logic short_gnd,
  output logic hall_input_pin,
  output logic hall_current_below,
  output logic hall_overcurrent_det
);
  logic float_reg = 1'b0;

  // an undriven pin wanders, so a stale level never reads as valid
  always_ff @(posedge clk_sys) begin
    float_reg <= ~float_reg;
  end

  // pin level: closed switch or short wins, else pull-up or supply
  always_comb begin
    if (switch_closed || short_gnd) begin
      hall_input_pin = 1'b0;
    end else if (hall_pullup_enable || hall_supply_drive) begin
      hall_input_pin = 1'b1;
    end else begin
      hall_input_pin = float_reg;
    end
  end

  // sensor draws high current when its output is on
  assign hall_current_below = ~(hall_sense_enable & (switch_closed | short_gnd));
  assign hall_overcurrent_det = hall_sense_enable & short_gnd;
endmodule
`default_nettype wire

/* sim/hall_wake_input_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module hall_wake_input_ctrl_test;
  import hall_wake_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  reg_req_type reg_req = '0;
  power_mode_type power_mode = mode_run;
  logic wake_input_pin = 1'b0;
  logic switch_closed = 1'b0;
  logic short_gnd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rd;
  logic hall_input_pin, hall_current_below, hall_overcurrent_det;
  logic hall_supply_drive, hall_sense_enable, hall_current_limit, hall_pullup_enable;
  logic hall_irq, wake_irq, wake_request;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [7:0] ctl = hall_wake_status_control_addr;

  hall_wake_input_ctrl u_hall_wake_input_ctrl (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .power_mode(power_mode), .hall_input_pin(hall_input_pin),
    .hall_current_below(hall_current_below), .hall_overcurrent_det(hall_overcurrent_det),
    .wake_input_pin(wake_input_pin), .hall_supply_drive(hall_supply_drive),
    .hall_sense_enable(hall_sense_enable), .hall_current_limit(hall_current_limit),
    .hall_pullup_enable(hall_pullup_enable), .hall_irq(hall_irq), .wake_irq(wake_irq),
    .wake_request(wake_request)
  );

  hall_sensor_model u_hall_sensor_model (
    .clk_sys(clk_sys), .hall_supply_drive(hall_supply_drive),
    .hall_sense_enable(hall_sense_enable), .hall_pullup_enable(hall_pullup_enable),
    .switch_closed(switch_closed), .short_gnd(short_gnd), .hall_input_pin(hall_input_pin),
    .hall_current_below(hall_current_below), .hall_overcurrent_det(hall_overcurrent_det)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.write <= 1'b1;
    @(posedge clk_sys);
    reg_req.write <= 1'b0;
    #1;
  endtask

  // data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.read <= 1'b1;
    @(posedge clk_sys);
    reg_req.read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run of about 2000 cycles
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h08);
    check(8'(hall_pullup_enable), 8'h01);
    check(8'(hall_supply_drive), 8'h00);
    reg_read(8'h08, rd);
    check(rd, 8'h00);
    reg_write(ctl, 8'h02);
    check(8'(hall_pullup_enable), 8'h00);
    reg_write(ctl, 8'h00);
    reg_write(irq_mask_addr, 8'h03);
    cyc(6);
    reg_write(irq_flag_addr, 8'h03);
    // general input: closing the switch pulls the pin low
    @(posedge clk_sys);
    switch_closed <= 1'b1;
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h00);
    check(8'(hall_irq), 8'h01);
    reg_write(irq_flag_addr, 8'h00);
    check(8'(hall_irq), 8'h01);
    reg_write(irq_flag_addr, 8'h01);
    check(8'(hall_irq), 8'h00);
    // hall masked: flag still sets, line stays low
    reg_write(irq_mask_addr, 8'h02);
    @(posedge clk_sys);
    switch_closed <= 1'b0;
    cyc(6);
    check(8'(hall_irq), 8'h00);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h01);
    // hall sensor mode, wait for the sensor to settle
    reg_write(ctl, 8'h05);
    check(8'(hall_supply_drive), 8'h01);
    check(8'(hall_sense_enable), 8'h01);
    check(8'(hall_pullup_enable), 8'h00);
    cyc(hall_settle_cycles);
    reg_write(irq_flag_addr, 8'h03);
    reg_read(ctl, rd);
    check(rd, 8'h0d);
    @(posedge clk_sys);
    switch_closed <= 1'b1;
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h05);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h01);
    // short to ground sets the sticky overcurrent flag
    @(posedge clk_sys);
    short_gnd <= 1'b1;
    cyc(6);
    check(8'(hall_current_limit), 8'h01);
    @(posedge clk_sys);
    short_gnd <= 1'b0;
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h15);
    reg_write(ctl, 8'h15);
    reg_read(ctl, rd);
    check(rd, 8'h05);
    reg_write(ctl, 8'h00);
    check(8'(hall_supply_drive), 8'h00);
    cyc(6);
    reg_write(irq_flag_addr, 8'h03);
    // wake pin in run mode
    @(posedge clk_sys);
    wake_input_pin <= 1'b1;
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h20);
    check(8'(wake_irq), 8'h01);
    reg_write(irq_flag_addr, 8'h02);
    check(8'(wake_irq), 8'h00);
    // stop mode: a change from the stored level wakes
    @(posedge clk_sys);
    power_mode <= mode_stop;
    cyc(4);
    @(posedge clk_sys);
    wake_input_pin <= 1'b0;
    cyc(6);
    check(8'(wake_request), 8'h01);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h00);
    reg_read(reset_status_addr, rd);
    check(rd, 8'h01);
    reg_write(reset_status_addr, 8'h01);
    reg_read(reset_status_addr, rd);
    check(rd, 8'h00);
    @(posedge clk_sys);
    power_mode <= mode_run;
    cyc(3);
    check(8'(wake_request), 8'h00);
    // hall mode with the port off draws no current, flag reads one
    reg_write(ctl, 8'h01);
    check(8'(hall_pullup_enable), 8'h00);
    check(8'(hall_sense_enable), 8'h00);
    cyc(6);
    reg_read(ctl, rd);
    check(rd, 8'h09);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h01);
    reg_write(ctl, 8'h00);
    cyc(6);
    reg_write(irq_flag_addr, 8'h03);
    // wake edge with its mask off: flag sets, line stays low
    reg_write(irq_mask_addr, 8'h01);
    @(posedge clk_sys);
    wake_input_pin <= 1'b1;
    cyc(6);
    check(8'(wake_irq), 8'h00);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h02);
    reg_write(irq_flag_addr, 8'h03);
    // sleep mode: wake change wakes, hall change is ignored
    @(posedge clk_sys);
    power_mode <= mode_sleep;
    cyc(4);
    @(posedge clk_sys);
    switch_closed <= 1'b0;
    wake_input_pin <= 1'b0;
    cyc(6);
    check(8'(wake_request), 8'h01);
    check(8'(hall_irq), 8'h00);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h00);
    reg_read(reset_status_addr, rd);
    check(rd, 8'h01);
    reg_write(reset_status_addr, 8'h01);
    @(posedge clk_sys);
    power_mode <= mode_run;
    cyc(3);
    check(8'(wake_request), 8'h00);
    reg_read(irq_flag_addr, rd);
    check(rd, 8'h00);
    reg_read(reset_status_addr, rd);
    check(rd, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
